// >>> rtl/smc_mode_ctrl.v
// Serial port mode register and pin-ownership control, Wishbone slave.
// Assumes synchronous pin inputs and a core that consumes the routed serial signals.
//
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "smc_consts.vh"

// Summary of operation
// - When enabled, the port owns the pins chosen by pin-use field and transmit enable.
// - When disabled, all pins return to the general-purpose port; core clock gated off.
// - Halt-in-idle set stops the port in Idle; clear keeps it running.
// - Infrared enable with loopback clear inserts encoder on transmit and decoder on receive.
// - Request pin mode 1 is simplex, 0 is flow control.
// - Code 11: transmit, receive and baud clock pins; clear-to-send stays general-purpose.
// - Code 10: transmit, receive, clear-to-send and request-to-send pins.
// - Code 01: transmit, receive and request-to-send; clear-to-send stays general-purpose.
// - Code 00: transmit and receive only.
// - Wake bit set: start bit on receive during Sleep wakes the device.
// - Loop return select set places the port in loopback mode.
// - Bits 31 to 16 and unimplemented bits read as zero.
module smc_mode_ctrl (
	input  wire        mclk_in,
	input  wire        srst_in,
	// Wishbone classic slave
	input  wire        wb_cyc_in,
	input  wire        wb_stb_in,
	input  wire        wb_we_in,
	input  wire [7:0]  wb_adr_in,
	input  wire [3:0]  wb_sel_in,
	input  wire [31:0] wb_dat_in,
	output reg  [31:0] wb_dat_out,
	output reg         wb_ack_out,
	// Device power state
	input  wire        idle_mode_in,
	input  wire        sleep_mode_in,
	// Core side
	input  wire        core_tx_in,
	input  wire        core_rts_in,
	input  wire        core_bclk_in,
	input  wire        transmit_enable_ctrl_in,
	output reg         core_rx_out,
	output reg         core_cts_out,
	output reg         core_run_out,
	output reg         core_ir_out,
	output reg         core_simplex_out,
	// Pins: output, enable, and ownership flags toward the port mux
	input  wire        rx_pin_in,
	input  wire        cts_n_pin_in,
	output reg         tx_pin_out,
	output reg         tx_oe_out,
	output reg         rts_n_pin_out,
	output reg         rts_oe_out,
	output reg         bclk_pin_out,
	output reg         bclk_oe_out,
	output reg         own_tx_out,
	output reg         own_rx_out,
	output reg         own_cts_out,
	output reg         own_rts_out,
	output reg         wake_req_out,
	output reg         irq_out
);

	reg  [31:0] mode_r;
	reg  [`SMC_EV_W-1:0] stat_r;
	reg  [`SMC_EV_W-1:0] stat_nxt;
	reg  [`SMC_EV_W-1:0] ien_r;
	reg         rx_prev_r;
	reg         ir_tx_r;
	reg  [31:0] rd_data;
	reg         on_prev_r;

	wire        req;
	wire        wr;
	wire        on;
	wire [1:0]  pins;
	wire        running;
	wire        rx_eff;
	wire        rx_raw;
	wire        start_edge;
	wire [`SMC_EV_W-1:0] ev;
	wire [31:0] wmask;

	// Byte-lane write mask built from sel
	function [31:0] lane_mask;
		input [3:0] sel;
		begin
			lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		end
	endfunction

	// Register address hit test, used by read and write decoders
	function hit;
		input [7:0] adr;
		input [7:0] target;
		begin
			hit = (adr == target);
		end
	endfunction

	assign req   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	assign wr    = req & wb_we_in;
	assign wmask = lane_mask(wb_sel_in);
	assign on    = mode_r[`SMC_BIT_ENABLE];
	assign pins  = mode_r[`SMC_BIT_PIN_HI:`SMC_BIT_PIN_LO];

	// Halting in Idle only when asked; otherwise run whenever enabled
	assign running = on & ~(idle_mode_in & mode_r[`SMC_BIT_HALT_IDLE]);

	// Receive source: internal loop or pin, optional polarity invert
	assign rx_raw = mode_r[`SMC_BIT_LOOP] ? core_tx_in : rx_pin_in;
	assign rx_eff = rx_raw ^ mode_r[`SMC_BIT_RECEIVE_POLARITY_INVERT];

	// Start bit is a falling edge on the idle-high line
	assign start_edge = rx_prev_r & ~rx_eff;

	// Events: wake-up, start seen while running, module switched off
	assign ev[`SMC_EV_WAKE]  = on & sleep_mode_in & mode_r[`SMC_BIT_WAKE] & start_edge;
	assign ev[`SMC_EV_START] = running & start_edge;
	assign ev[`SMC_EV_OFF]   = on_prev_r & ~on;

	// Mode register; unimplemented bits masked so they always read zero
	always @(posedge mclk_in) begin
		if (srst_in) begin
			mode_r <= `SMC_MODE_RESET;
		end else if (wr && hit(wb_adr_in, `SMC_ADDR_MODE)) begin
			mode_r <= ((mode_r & ~wmask) | (wb_dat_in & wmask)) & `SMC_MODE_MASK;
		end
	end

	// Sticky status: a set in the same cycle as a clear wins
	always @* begin
		stat_nxt = stat_r;
		if (wr && hit(wb_adr_in, `SMC_ADDR_IRQ_CLR)) begin
			stat_nxt = stat_r & ~wb_dat_in[`SMC_EV_W-1:0];
		end
		stat_nxt = stat_nxt | ev;
	end

	always @(posedge mclk_in) begin
		if (srst_in) begin
			stat_r    <= {`SMC_EV_W{1'b0}};
			ien_r     <= {`SMC_EV_W{1'b0}};
			rx_prev_r <= 1'b1;
			on_prev_r <= 1'b0;
		end else begin
			stat_r    <= stat_nxt;
			rx_prev_r <= rx_eff;
			on_prev_r <= on;
			if (wr && hit(wb_adr_in, `SMC_ADDR_IRQ_EN) && wb_sel_in[0]) begin
				ien_r <= wb_dat_in[`SMC_EV_W-1:0];
			end
		end
	end

	// Read mux; unmapped addresses read zero and still ack
	always @* begin
		rd_data = 32'h0000_0000;
		if (hit(wb_adr_in, `SMC_ADDR_MODE)) begin
			rd_data = mode_r;
		end else if (hit(wb_adr_in, `SMC_ADDR_IRQ_STAT)) begin
			rd_data = {{(32-`SMC_EV_W){1'b0}}, stat_r};
		end else if (hit(wb_adr_in, `SMC_ADDR_IRQ_EN)) begin
			rd_data = {{(32-`SMC_EV_W){1'b0}}, ien_r};
		end else if (hit(wb_adr_in, `SMC_ADDR_STATUS)) begin
			rd_data = {27'h000_0000, own_rts_out, own_cts_out, own_rx_out,
				own_tx_out, core_run_out};
		end
	end

	// One-cycle ack, one cycle after the request is seen
	always @(posedge mclk_in) begin
		if (srst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			wb_ack_out <= req;
			wb_dat_out <= req ? rd_data : 32'h0000_0000;
		end
	end

	// Pin ownership from the pin-use field; all released when off
	always @(posedge mclk_in) begin
		if (srst_in || !on) begin
			own_tx_out  <= 1'b0;
			own_rx_out  <= 1'b0;
			own_cts_out <= 1'b0;
			own_rts_out <= 1'b0;
			bclk_oe_out <= 1'b0;
			tx_oe_out   <= 1'b0;
			rts_oe_out  <= 1'b0;
		end else begin
			own_tx_out  <= 1'b1;
			own_rx_out  <= 1'b1;
			tx_oe_out   <= transmit_enable_ctrl_in;
			case (pins)
			`SMC_PINS_BCLK: begin
				own_cts_out <= 1'b0;
				own_rts_out <= 1'b0;
				rts_oe_out  <= 1'b0;
				bclk_oe_out <= 1'b1;
			end
			`SMC_PINS_FLOW: begin
				own_cts_out <= 1'b1;
				own_rts_out <= 1'b1;
				rts_oe_out  <= 1'b1;
				bclk_oe_out <= 1'b0;
			end
			`SMC_PINS_RTS: begin
				own_cts_out <= 1'b0;
				own_rts_out <= 1'b1;
				rts_oe_out  <= 1'b1;
				bclk_oe_out <= 1'b0;
			end
			default: begin
				own_cts_out <= 1'b0;
				own_rts_out <= 1'b0;
				rts_oe_out  <= 1'b0;
				bclk_oe_out <= 1'b0;
			end
			endcase
		end
	end

	// Infrared encode: a transmitted zero becomes a short high pulse.
	// Simplified to an inverted copy, high for the whole low bit; the pulse width is the core's job.
	always @(posedge mclk_in) begin
		if (srst_in) begin
			ir_tx_r <= 1'b0;
		end else begin
			ir_tx_r <= ~core_tx_in;
		end
	end

	// Data path registers; reset loads idle levels, and they keep following their sources while off
	always @(posedge mclk_in) begin
		if (srst_in) begin
			tx_pin_out       <= 1'b1;
			rts_n_pin_out    <= 1'b1;
			bclk_pin_out     <= 1'b0;
			core_rx_out      <= 1'b1;
			core_cts_out     <= 1'b0;
			core_run_out     <= 1'b0;
			core_ir_out      <= 1'b0;
			core_simplex_out <= 1'b0;
			wake_req_out     <= 1'b0;
			irq_out          <= 1'b0;
		end else begin
			core_run_out     <= running;
			core_ir_out      <= mode_r[`SMC_BIT_IR_EN];
			core_simplex_out <= mode_r[`SMC_BIT_RTS_MODE];
			// Loopback keeps the external transmit pin idle-high
			if (mode_r[`SMC_BIT_LOOP]) begin
				tx_pin_out <= 1'b1;
			end else if (mode_r[`SMC_BIT_IR_EN]) begin
				tx_pin_out <= ir_tx_r;
			end else begin
				tx_pin_out <= core_tx_in;
			end
			// Decoder turns an active-high pulse back into a low bit
			core_rx_out  <= (mode_r[`SMC_BIT_IR_EN] && !mode_r[`SMC_BIT_LOOP]) ?
				~rx_eff : rx_eff;
			// Flow-control mode follows the core; simplex drives when transmitting
			rts_n_pin_out <= mode_r[`SMC_BIT_RTS_MODE] ? ~transmit_enable_ctrl_in :
				core_rts_in;
			bclk_pin_out <= core_bclk_in;
			core_cts_out <= own_cts_out ? ~cts_n_pin_in : 1'b1;
			wake_req_out <= ev[`SMC_EV_WAKE];
			irq_out      <= |(stat_nxt & ien_r);
		end
	end

endmodule

// >>> rtl/smc_consts.vh
// Constants for the serial mode and pin-use control block.
// Assumes a 32-bit classic Wishbone slave port with word-aligned byte addresses.
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH

// Register byte offsets
`define SMC_ADDR_MODE       8'h00
`define SMC_ADDR_IRQ_STAT   8'h04
`define SMC_ADDR_IRQ_EN     8'h08
`define SMC_ADDR_IRQ_CLR    8'h0C
`define SMC_ADDR_STATUS     8'h10

// Mode register field positions
`define SMC_BIT_ENABLE      15
`define SMC_BIT_HALT_IDLE   13
`define SMC_BIT_IR_EN       12
`define SMC_BIT_RTS_MODE    11
`define SMC_BIT_PIN_HI      9
`define SMC_BIT_PIN_LO      8
`define SMC_BIT_WAKE        7
`define SMC_BIT_LOOP        6
`define SMC_BIT_AUTO_RATE_DETECT       5
`define SMC_BIT_RECEIVE_POLARITY_INVERT       4
`define SMC_BIT_HIGH_SPEED_RATE_SELECT        3
`define SMC_BIT_PARITY_WIDTH_SELECT_HI    2
`define SMC_BIT_PARITY_WIDTH_SELECT_LO    1
`define SMC_BIT_STOP_BIT_SELECT       0

// Writable bits of the mode register; all others read zero
`define SMC_MODE_MASK       32'h0000_BBFF
`define SMC_MODE_RESET      32'h0000_0000

// Pin-use field codes
`define SMC_PINS_TXRX       2'h0
`define SMC_PINS_RTS        2'h1
`define SMC_PINS_FLOW       2'h2
`define SMC_PINS_BCLK       2'h3

// Event bit positions (status, enable and clear share the layout)
`define SMC_EV_WAKE         0
`define SMC_EV_START        1
`define SMC_EV_OFF          2
`define SMC_EV_W            3

`endif

// >>> tb/smc_mode_ctrl_assertions.sv
// Port-level checks for the serial mode control block.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
module smc_mode_ctrl_assertions (
	input wire        mclk_in,
	input wire        srst_in,
	input wire        wb_cyc_in,
	input wire        wb_stb_in,
	input wire        wb_we_in,
	input wire        wb_ack_out,
	input wire [31:0] wb_dat_out,
	input wire        own_tx_out,
	input wire        own_rx_out,
	input wire        own_cts_out,
	input wire        own_rts_out,
	input wire        bclk_oe_out,
	input wire        core_run_out
);
	// All checks sample on the one clock and sleep through reset
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack stood longer than one cycle");
	chk_ack_taken: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("request not answered in one cycle");
	chk_read_upper: assert property (
		wb_ack_out && !wb_we_in |-> wb_dat_out[31:16] == 16'h0000)
		else $error("upper read half not zero");
	chk_own_pair: assert property (own_tx_out == own_rx_out)
		else $error("transmit and receive ownership differ");
	chk_off_release: assert property (
		!own_tx_out |-> !own_cts_out && !own_rts_out && !bclk_oe_out)
		else $error("pin held while port disabled");
	chk_cts_rts: assert property (own_cts_out |-> own_rts_out && own_tx_out)
		else $error("clear-to-send owned without request pin");
	chk_bclk_excl: assert property (
		bclk_oe_out |-> own_tx_out && !own_rts_out && !own_cts_out)
		else $error("baud clock driven with wrong pin set");
	chk_run_owned: assert property (core_run_out |-> own_tx_out)
		else $error("core running while disabled");
endmodule

bind smc_mode_ctrl smc_mode_ctrl_assertions smc_mode_ctrl_assertions_i (
	.mclk_in(mclk_in), .srst_in(srst_in), .wb_cyc_in(wb_cyc_in),
	.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_ack_out(wb_ack_out),
	.wb_dat_out(wb_dat_out), .own_tx_out(own_tx_out), .own_rx_out(own_rx_out),
	.own_cts_out(own_cts_out), .own_rts_out(own_rts_out),
	.bclk_oe_out(bclk_oe_out), .core_run_out(core_run_out));

// >>> tb/smc_line_partner.sv
// Serial line partner: idles high, sends a start bit on request.
// Assumes the same clock as the block; clear-to-send always granted.
`timescale 1ns/1ps
module smc_line_partner (
	input  wire mclk_in,
	input  wire send_in,
	output reg  rx_out,
	output wire cts_n_out
);
	reg [2:0] cnt_r = 3'h0;
	assign cts_n_out = 1'b0;
	initial rx_out = 1'b1;
	// Start bit four cycles low, then back to the idle mark level
	always @(posedge mclk_in) begin
		if (send_in)
			cnt_r <= 3'h4;
		else if (cnt_r != 3'h0)
			cnt_r <= cnt_r - 3'h1;
		rx_out <= !(send_in || cnt_r > 3'h1);
	end
endmodule

// >>> tb/smc_mode_ctrl_test.sv
// Self-checking bench for the serial mode control block.
// Assumes the bound checker and the line partner beside it.
`timescale 1ns/1ps
`include "smc_consts.vh"
module smc_mode_ctrl_test;
	reg        mclk_in = 1'b0, srst_in = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	reg        idle = 1'b0, slp = 1'b0, ctx = 1'b1, send = 1'b0;
	reg [7:0]  adr = 8'h00;
	reg [31:0] dat = 32'h0000_0000, q;
	integer    failures = 0, cmp_count = 0, c;
	wire       rx, cts_n, ack, crx, run, ir, smp, txp, boe, irq, rts;
	wire [31:0] rdat;
	always #2.5 mclk_in = ~mclk_in;
	smc_mode_ctrl smc_mode_ctrl_i (.mclk_in(mclk_in), .srst_in(srst_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat),
		.wb_dat_out(rdat), .wb_ack_out(ack), .idle_mode_in(idle), .sleep_mode_in(slp),
		.core_tx_in(ctx), .core_rts_in(1'b1), .core_bclk_in(1'b0),
		.transmit_enable_ctrl_in(1'b1), .core_rx_out(crx), .core_cts_out(),
		.core_run_out(run), .core_ir_out(ir), .core_simplex_out(smp), .rx_pin_in(rx),
		.cts_n_pin_in(cts_n), .tx_pin_out(txp), .tx_oe_out(), .rts_n_pin_out(rts),
		.rts_oe_out(), .bclk_pin_out(), .bclk_oe_out(boe), .own_tx_out(), .own_rx_out(),
		.own_cts_out(), .own_rts_out(), .wake_req_out(), .irq_out(irq));
	smc_line_partner smc_line_partner_i (.mclk_in(mclk_in), .send_in(send), .rx_out(rx),
		.cts_n_out(cts_n));
	task check(input string n, input [31:0] s, input [31:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (s !== e) begin
				failures = failures + 1;
				$display("[FAIL] %0s expected %h seen %h", n, e, s);
			end
		end
	endtask
	// One classic cycle; request held until ack is sampled high
	task bus(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge mclk_in);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			dat <= d;
			@(posedge mclk_in);
			while (ack !== 1'b1) @(posedge mclk_in);
			q = rdat;
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask
	// Registered outputs follow the mode register one edge late
	task settle;
		repeat (3) @(negedge mclk_in);
	endtask
	task pulse;
		begin
			send <= 1'b1;
			@(posedge mclk_in);
			send <= 1'b0;
			repeat (8) @(negedge mclk_in);
		end
	endtask
	task wrap_up;
		begin
			$display("compares %0d mismatches %0d", cmp_count, failures);
			if (failures == 0 && cmp_count > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	initial begin
		repeat (12) @(posedge mclk_in);
		srst_in <= 1'b0;
		bus(0, `SMC_ADDR_MODE, 0);
		check("mode reset", q, 32'h0000_0000);
		bus(1, `SMC_ADDR_MODE, 32'hffff_ffff);
		bus(0, `SMC_ADDR_MODE, 0);
		check("mode readback", q, 32'h0000_bbff);
		bus(0, 8'h20, 0);
		check("unmapped", q, 32'h0000_0000);
		for (c = 0; c < 4; c = c + 1) begin
			bus(1, `SMC_ADDR_MODE, 32'h0000_8000 | (c << 8));
			bus(0, `SMC_ADDR_STATUS, 0);
			check("pin owners", q, {27'h0, c == 1 || c == 2, c == 2, 3'b111});
			check("bclk drive", boe, c == 3);
		end
		bus(1, `SMC_ADDR_MODE, 32'h0000_a000);
		idle <= 1'b1;
		settle;
		check("halt in idle", run, 0);
		bus(1, `SMC_ADDR_MODE, 32'h0000_9800);
		settle;
		check("run in idle", run, 1);
		check("codec and simplex", {ir, smp}, 3);
		check("simplex rts", rts, 0);
		bus(1, `SMC_ADDR_MODE, 32'h0000_8040);
		ctx <= 1'b0;
		idle <= 1'b0;
		settle;
		check("codec flow off", {ir, smp}, 0);
		check("flow rts", rts, 1);
		check("loop receive", crx, 0);
		check("loop tx idle", txp, 1);
		bus(1, `SMC_ADDR_IRQ_EN, 1);
		ctx <= 1'b1;
		slp <= 1'b1;
		bus(1, `SMC_ADDR_MODE, 32'h0000_8080);
		pulse;
		check("wake irq", irq, 1);
		bus(0, `SMC_ADDR_IRQ_STAT, 0);
		check("wake flag", q[0], 1);
		bus(1, `SMC_ADDR_IRQ_EN, 0);
		settle;
		check("irq masked", irq, 0);
		bus(1, `SMC_ADDR_IRQ_EN, 7);
		bus(1, `SMC_ADDR_IRQ_CLR, 7);
		bus(0, `SMC_ADDR_IRQ_STAT, 0);
		check("flags cleared", q, 0);
		bus(1, `SMC_ADDR_MODE, 32'h0000_8000);
		pulse;
		bus(0, `SMC_ADDR_IRQ_STAT, 0);
		check("no wake", q[0], 0);
		bus(1, `SMC_ADDR_MODE, 0);
		bus(0, `SMC_ADDR_STATUS, 0);
		check("pins released", q, 0);
		bus(0, `SMC_ADDR_IRQ_STAT, 0);
		check("off event", q[2], 1);
		check("irq raised", irq, 1);
		wrap_up;
	end
	// Hang guard, far beyond the hundred-odd cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk_in);
		failures = failures + 1;
		wrap_up;
	end
endmodule
